// ==== core/strap_regs.vh ====
// constants for the strap latch, indicator and rmii data path
`ifndef STRAP_REGS_VH
`define STRAP_REGS_VH

`define PCLK_PERIOD_NS   8
`define BLINK_HALF_MS    50
`define BLINK_HALF_CYC   (`BLINK_HALF_MS * 1000000 / `PCLK_PERIOD_NS)
`define SYNC_FILL        2'h3

// register indices, byte address is four times the index
`define IDX_BASIC_CTL    8'h00
`define IDX_ADVERT       8'h04
`define IDX_STRAP_STAT   8'h10
`define IDX_LED_CTL      8'h1E

`define BCTL_SPEED       13
`define BCTL_ANEG        12
`define BCTL_ISOLATE     10
`define BCTL_DUPLEX      8
`define BCTL_RESET       16'h3000

`define ADV_100_FD       8
`define ADV_100_HD       7
`define ADV_RESET        16'h01E1

`define LED_MODE_HI      15
`define LED_MODE_LO      14
`define LED_MODE_SPEED   2'h0
`define LED_MODE_ACT     2'h1

`define STAT_ADDR_LSB    0
`define STAT_IF_LSB      5
`define STAT_IF_VALID    8
`define STAT_TX_OVERRUN  9
`define STAT_CAPTURED    10

`define IF_SEL_RMII      3'h1

// strap pin vector layout
`define STRAP_W          10
`define STRAP_ADDR_LSB   0
`define STRAP_IF_LSB     3
`define STRAP_ISO        6
`define STRAP_SPEED      7
`define STRAP_DUPLEX     8
`define STRAP_ANEG       9

`endif

// ==== core/pair_buffer.v ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem0_r;
  reg [WIDTH-1:0] mem1_r;
  reg             wr_ptr_r;
  reg             rd_ptr_r;
  reg [1:0]       count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = rd_ptr_r ? mem1_r : mem0_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem0_r   <= {WIDTH{1'b0}};
      mem1_r   <= {WIDTH{1'b0}};
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        if (wr_ptr_r)
          mem1_r <= in_data;
        else
          mem0_r <= in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push)
        count_r <= count_r - 2'h1;
    end
  end
endmodule

// ==== core/strap_latch_top.v ====
// strap capture, control registers over apb, second indicator and rmii data path
`timescale 1ns/1ps
`include "strap_regs.vh"
module strap_latch_top #(
  parameter BLINK_HALF_CYCLES = `BLINK_HALF_CYC
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [9:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire [`STRAP_W-1:0]  strap_pin_in,
  output reg  [`STRAP_W-1:0]  strap_pin_out,
  output reg  [`STRAP_W-1:0]  strap_pin_oe,
  input  wire                 ref_clk,
  input  wire                 tx_en,
  input  wire [1:0]           txd,
  output reg                  crs_dv,
  output reg  [1:0]           rxd,
  output wire [1:0]           tx_word,
  output wire                 tx_word_valid,
  input  wire                 tx_word_ready,
  input  wire [1:0]           rx_word,
  input  wire                 rx_word_valid,
  output wire                 rx_word_ready
);
  localparam SW = `STRAP_W + 4;
  localparam [1:0] ST_FILL  = 2'h0;
  localparam [1:0] ST_CHECK = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [31:0] BLINK_LAST = BLINK_HALF_CYCLES - 1;
  localparam [31:0] HOLD_LAST  = 2 * BLINK_HALF_CYCLES - 1;

  reg  [SW-1:0]  s1_r;
  reg  [SW-1:0]  s2_r;
  reg  [SW-1:0]  s3_r;
  reg  [1:0]     cap_state_r;
  reg  [1:0]     fill_cnt_r;
  reg  [15:0]    bctl_r;
  reg  [15:0]    adv_r;
  reg  [1:0]     led_mode_r;
  reg  [2:0]     addr_strap_r;
  reg  [2:0]     if_sel_r;
  reg            tx_overrun_r;
  reg            ref_lvl_r;
  reg            led_r;
  reg            blink_r;
  reg  [31:0]    blink_cnt_r;
  reg  [31:0]    hold_cnt_r;
  reg  [31:0]    rd_data_nxt;
  reg            rd_err_nxt;
  reg  [15:0]    stat_nxt;
  reg            led_nxt;

  wire [7:0]     reg_idx;
  wire           setup_ph;
  wire           wr_acc;
  wire           running;
  wire           ref_agree;
  wire           ref_rise;
  wire           ref_fall;
  wire           tx_en_s;
  wire [1:0]     txd_s;
  wire           tx_push;
  wire           tx_buf_ready;
  wire           rx_pop;
  wire           rx_out_valid;
  wire [1:0]     rx_out_data;
  wire           activity;
  wire [`STRAP_W-1:0] strap_s;
  wire [`STRAP_W-1:0] strap_agree;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers for pins and the link clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= {SW{1'b0}};
      s2_r <= {SW{1'b0}};
      s3_r <= {SW{1'b0}};
    end
    else
    begin
      s1_r <= {ref_clk, tx_en, txd, strap_pin_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign strap_s     = s3_r[`STRAP_W-1:0];
  assign strap_agree = s2_r[`STRAP_W-1:0] ^ s3_r[`STRAP_W-1:0];
  assign txd_s       = s3_r[`STRAP_W+1:`STRAP_W];
  assign tx_en_s     = s3_r[`STRAP_W+2];
  assign ref_agree   = (s2_r[SW-1] == s3_r[SW-1]);
  assign ref_rise    = ref_agree & s3_r[SW-1] & ~ref_lvl_r;
  assign ref_fall    = ref_agree & ~s3_r[SW-1] & ref_lvl_r;
  assign running     = (cap_state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_state_r   <= ST_FILL;
      fill_cnt_r    <= 2'h0;
      addr_strap_r  <= 3'h0;
      if_sel_r      <= 3'h0;
      strap_pin_oe  <= {`STRAP_W{1'b0}};
      strap_pin_out <= {`STRAP_W{1'b0}};
    end
    else
    begin
      case (cap_state_r)
        ST_FILL:
        begin
          fill_cnt_r <= fill_cnt_r + 2'h1;
          if (fill_cnt_r == `SYNC_FILL - 2'h1)
            cap_state_r <= ST_CHECK;
        end
        ST_CHECK:
        begin
          if (strap_agree == {`STRAP_W{1'b0}})
          begin
            addr_strap_r <= strap_s[`STRAP_ADDR_LSB+2:`STRAP_ADDR_LSB];
            if_sel_r     <= strap_s[`STRAP_IF_LSB+2:`STRAP_IF_LSB];
            cap_state_r  <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          strap_pin_oe  <= {`STRAP_W{1'b1}};
          strap_pin_out <= {`STRAP_W{1'b0}};
          strap_pin_out[`STRAP_SPEED] <= led_r;
        end
        default:
          cap_state_r <= ST_FILL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign reg_idx  = paddr[9:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;

  always @*
  begin
    stat_nxt = 16'h0000;
    stat_nxt[`STAT_ADDR_LSB+4:`STAT_ADDR_LSB] = {2'b00, addr_strap_r};
    stat_nxt[`STAT_IF_LSB+2:`STAT_IF_LSB]     = if_sel_r;
    stat_nxt[`STAT_IF_VALID]   = (if_sel_r == `IF_SEL_RMII);
    stat_nxt[`STAT_TX_OVERRUN] = tx_overrun_r;
    stat_nxt[`STAT_CAPTURED]   = running;
    rd_err_nxt  = 1'b0;
    rd_data_nxt = 32'h0000_0000;
    case (reg_idx)
      `IDX_BASIC_CTL:  rd_data_nxt = {16'h0000, bctl_r};
      `IDX_ADVERT:     rd_data_nxt = {16'h0000, adv_r};
      `IDX_STRAP_STAT: rd_data_nxt = {16'h0000, stat_nxt};
      `IDX_LED_CTL:    rd_data_nxt = {16'h0000, led_mode_r, 14'h0000};
      default:         rd_err_nxt  = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup_ph)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data_nxt;
        pslverr <= rd_err_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // basic control and advertisement registers, loaded from straps on capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bctl_r       <= `BCTL_RESET;
      adv_r        <= `ADV_RESET;
      led_mode_r   <= `LED_MODE_SPEED;
      tx_overrun_r <= 1'b0;
    end
    else
    begin
      if (cap_state_r == ST_CHECK && strap_agree == {`STRAP_W{1'b0}})
      begin
        bctl_r[`BCTL_ISOLATE] <= strap_s[`STRAP_ISO];
        bctl_r[`BCTL_SPEED]   <= strap_s[`STRAP_SPEED];
        bctl_r[`BCTL_DUPLEX]  <= ~strap_s[`STRAP_DUPLEX];
        bctl_r[`BCTL_ANEG]    <= strap_s[`STRAP_ANEG];
        adv_r[`ADV_100_FD]    <= strap_s[`STRAP_SPEED];
        adv_r[`ADV_100_HD]    <= strap_s[`STRAP_SPEED];
      end
      else if (wr_acc)
      begin
        case (reg_idx)
          `IDX_BASIC_CTL:
          begin
            bctl_r[`BCTL_ISOLATE] <= pwdata[`BCTL_ISOLATE];
            bctl_r[`BCTL_SPEED]   <= pwdata[`BCTL_SPEED];
            bctl_r[`BCTL_DUPLEX]  <= pwdata[`BCTL_DUPLEX];
            bctl_r[`BCTL_ANEG]    <= pwdata[`BCTL_ANEG];
          end
          `IDX_ADVERT:  adv_r      <= pwdata[15:0];
          `IDX_LED_CTL: led_mode_r <= pwdata[`LED_MODE_HI:`LED_MODE_LO];
          default:      led_mode_r <= led_mode_r;
        endcase
      end
      // overrun sticky: a new overrun wins over a write-one clear
      if (tx_push && !tx_buf_ready)
        tx_overrun_r <= 1'b1;
      else if (wr_acc && reg_idx == `IDX_STRAP_STAT && pwdata[`STAT_TX_OVERRUN])
        tx_overrun_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rmii data path on detected reference clock edges
  assign tx_push = running & ref_rise & tx_en_s & ~bctl_r[`BCTL_ISOLATE];
  assign rx_pop  = running & ref_fall & rx_out_valid & ~bctl_r[`BCTL_ISOLATE];

  pair_buffer #(
    .WIDTH (2)
  ) u_tx_buf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (tx_push),
    .in_ready  (tx_buf_ready),
    .in_data   (txd_s),
    .out_valid (tx_word_valid),
    .out_ready (tx_word_ready),
    .out_data  (tx_word)
  );

  pair_buffer #(
    .WIDTH (2)
  ) u_rx_buf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (rx_word_valid),
    .in_ready  (rx_word_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data)
  );

  // receive pair changes on the falling edge, mac samples on the rising one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_lvl_r <= 1'b0;
      crs_dv    <= 1'b0;
      rxd       <= 2'h0;
    end
    else
    begin
      if (ref_agree)
        ref_lvl_r <= s3_r[SW-1];
      if (ref_fall)
      begin
        crs_dv <= rx_pop;
        rxd    <= rx_pop ? rx_out_data : 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second indicator
  assign activity = (hold_cnt_r != 32'h0000_0000);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt_r  <= 32'h0000_0000;
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b1;
    end
    else
    begin
      if (tx_push || rx_pop)
        hold_cnt_r <= HOLD_LAST;
      else if (activity)
        hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
      if (!activity)
      begin
        blink_cnt_r <= 32'h0000_0000;
        blink_r     <= 1'b1;
      end
      else if (blink_cnt_r == BLINK_LAST)
      begin
        blink_cnt_r <= 32'h0000_0000;
        blink_r     <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  always @*
  begin
    case (led_mode_r)
      `LED_MODE_SPEED: led_nxt = ~bctl_r[`BCTL_SPEED];
      `LED_MODE_ACT:   led_nxt = blink_r;
      default:         led_nxt = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_r <= 1'b1;
    else
      led_r <= led_nxt;
  end
endmodule

// ==== verification/strap_latch_assertions.sv ====
// checker on the strap latch top ports
`timescale 1ns/1ps
module strap_latch_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [9:0]  paddr,
  input wire [31:0] prdata,
  input wire [9:0]  strap_pin_out,
  input wire [9:0]  strap_pin_oe,
  input wire        crs_dv,
  input wire [1:0]  rxd,
  input wire [1:0]  tx_word,
  input wire        tx_word_valid,
  input wire        tx_word_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence stat_rd;
    psel && !penable && !pwrite && paddr == 10'h040;
  endsequence
  sequence rx_hold;
    crs_dv && $stable(rxd);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_quiet_after_rst: assert property ($rose(presetn) |-> (strap_pin_oe == 10'h000) [*3])
    else $error("strap pins driven too early");
  a_release_bounded: assert property ($rose(presetn) |-> ##[4:8] strap_pin_oe[7])
    else $error("indicator pin not released");
  a_drive_sticks: assert property (strap_pin_oe[7] |=> strap_pin_oe[7])
    else $error("indicator pin drive dropped");
  a_other_pins_low: assert property (strap_pin_oe[7] |-> strap_pin_out[6:0] == 7'h00
    && strap_pin_out[9:8] == 2'h0)
    else $error("strap pin output not low");
  a_rx_idle_zero: assert property (!crs_dv |-> rxd == 2'h0)
    else $error("rxd not zero while idle");
  a_rx_dibit_stands: assert property ($rose(crs_dv) |=> rx_hold [*8])
    else $error("rx dibit changed within period");
  a_tx_word_hold: assert property (tx_word_valid && !tx_word_ready |=>
    tx_word_valid && $stable(tx_word))
    else $error("tx word dropped while stalled");
  a_addr_top_zero: assert property (stat_rd |=> prdata[4:3] == 2'h0
    && prdata[31:16] == 16'h0000)
    else $error("port address upper bits set");
endmodule
bind strap_latch_top strap_latch_assertions strap_latch_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .strap_pin_out(strap_pin_out),
  .strap_pin_oe(strap_pin_oe), .crs_dv(crs_dv), .rxd(rxd), .tx_word(tx_word),
  .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready));

// ==== verification/mac_model.sv ====
// rmii mac model: reference clock, dibit sender, dibit collector
`timescale 1ns/1ps
module mac_model (
  output reg       ref_clk,
  output reg       tx_en,
  output reg [1:0] txd,
  input wire       crs_dv,
  input wire [1:0] rxd
);
  logic [1:0] got[$];
  initial
  begin
    ref_clk = 1'b0;
    tx_en = 1'b0;
    txd = 2'h0;
  end
  always #62.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (crs_dv)
      got.push_back(rxd);
  // drive on falling edge, stable at rising
  task send(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 4; i++)
      begin
        @(negedge ref_clk);
        tx_en <= 1'b1;
        txd <= b[2*i +: 2];
      end
      @(negedge ref_clk);
      tx_en <= 1'b0;
      txd <= ~b[7:6];
    end
  endtask
endmodule

// ==== verification/strap_latch_top_test.sv ====
// self-checking bench for the strap latch top
`timescale 1ns/1ps
module strap_latch_top_test;
  reg         pclk, presetn, psel, penable, pwrite, tx_word_ready, rx_word_valid;
  reg  [9:0]  paddr, strap_val;
  reg  [31:0] pwdata;
  reg  [1:0]  rx_word;
  wire [31:0] prdata;
  wire        pready, pslverr, ref_clk, tx_en, crs_dv, tx_word_valid, rx_word_ready;
  wire [9:0]  pin_out, pin_oe;
  wire [1:0]  txd, rxd, tx_word;
  integer     mismatches, n_compared, toggles, stalls;
  // pin level: device drive, else board pull
  wire [9:0]  pins = (pin_oe & pin_out) | (~pin_oe & strap_val);
  strap_latch_top #(.BLINK_HALF_CYCLES(8)) strap_latch_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_pin_in(pins), .strap_pin_out(pin_out), .strap_pin_oe(pin_oe),
    .ref_clk(ref_clk), .tx_en(tx_en), .txd(txd), .crs_dv(crs_dv), .rxd(rxd),
    .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready));
  mac_model mac_model_i (.ref_clk(ref_clk), .tx_en(tx_en), .txd(txd), .crs_dv(crs_dv),
    .rxd(rxd));
  always #4 pclk = ~pclk;
  always @(pin_out[7]) toggles++;
  ////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_compared++;
      if (g !== x)
      begin
        mismatches++;
        $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task apb(input w, input [9:0] a, input [31:0] d, output [31:0] r, output e);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
        mismatches++;
        test_done;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [9:0] a, input [31:0] x);
    reg [31:0] r;
    reg        e;
    begin
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
    end
  endtask
  task wr(input [9:0] a, input [31:0] d);
    reg [31:0] r;
    reg        e;
    begin
      apb(1'b1, a, d, r, e);
    end
  endtask
  task led_is(input v);
    begin
      repeat (3) @(posedge pclk);
      chk({31'h0, pin_out[7]}, {31'h0, v});
    end
  endtask
  task pop(input [1:0] x);
    integer k;
    begin
      k = 0;
      do
      begin
        @(negedge pclk);
        k++;
      end
      while (tx_word_valid !== 1'b1 && k < 200);
      if (tx_word_valid !== 1'b1)
      begin
        mismatches++;
        test_done;
      end
      chk({30'h0, tx_word}, {30'h0, x});
      @(posedge pclk);
      tx_word_ready <= 1'b1;
      @(posedge pclk);
      tx_word_ready <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task push(input [1:0] w);
    integer k;
    begin
      rx_word <= w;
      rx_word_valid <= 1'b1;
      k = 0;
      do
      begin
        @(negedge pclk);
        k++;
      end
      while (rx_word_ready !== 1'b1 && k < 200);
      if (rx_word_ready !== 1'b1)
      begin
        mismatches++;
        test_done;
      end
      if (k > 1)
        stalls++;
      @(posedge pclk);
    end
  endtask
  task rst(input [9:0] s);
    begin
      presetn <= 1'b0;
      strap_val <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_straps(input [9:0] s, input [31:0] ctl, adv, st, input v);
    begin
      rst(s);
      chk({31'h0, pin_oe[7]}, 32'h0000_0001);
      led_is(v);
      rd(10'h000, ctl);
      rd(10'h010, adv);
      rd(10'h040, st);
      $display("straps %h done", s);
    end
  endtask
  task t_led;
    reg [31:0] r;
    reg        e;
    begin
      wr(10'h000, 32'h0000_1000);
      led_is(1'b1);
      wr(10'h000, 32'h0000_3000);
      led_is(1'b0);
      wr(10'h078, 32'h0000_8000);
      led_is(1'b1);
      wr(10'h078, 32'h0000_c000);
      led_is(1'b1);
      apb(1'b0, 10'h3fc, 32'h0, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      wr(10'h078, 32'h0000_4000);
      led_is(1'b1);
      $display("led modes done");
    end
  endtask
  task t_tx;
    begin
      mac_model_i.send(8'hb4);
      repeat (10) @(posedge pclk);
      rd(10'h040, 32'h0000_0721);
      pop(2'h0);
      pop(2'h1);
      wr(10'h040, 32'h0000_0200);
      rd(10'h040, 32'h0000_0521);
      toggles = 0;
      fork
        mac_model_i.send(8'h1b);
        begin
          pop(2'h3);
          pop(2'h2);
          pop(2'h1);
          pop(2'h0);
        end
      join
      chk({31'h0, toggles > 2}, 32'h0000_0001);
      repeat (40) @(posedge pclk);
      led_is(1'b1);
      $display("rmii transmit done");
    end
  endtask
  task t_rx;
    integer   k;
    reg [7:0] w;
    begin
      w = 8'h36;
      stalls = 0;
      for (k = 0; k < 4; k++)
        push(w[2*k +: 2]);
      rx_word_valid <= 1'b0;
      rx_word <= 2'h3;
      chk({31'h0, stalls > 0}, 32'h0000_0001);
      k = 0;
      while (mac_model_i.got.size() < 4 && k < 300)
      begin
        @(negedge pclk);
        k++;
      end
      if (mac_model_i.got.size() < 4)
      begin
        mismatches++;
        test_done;
      end
      for (k = 0; k < 4; k++)
        chk({30'h0, mac_model_i.got[k]}, {24'h0, 6'h0, w[2*k +: 2]});
      $display("rmii receive done");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    strap_val = 10'h389;
    tx_word_ready = 1'b0;
    rx_word_valid = 1'b0;
    rx_word = 2'h0;
    mismatches = 0;
    n_compared = 0;
    toggles = 0;
    t_straps(10'h057, 32'h0000_0500, 32'h0000_0061, 32'h0000_0447, 1'b1);
    t_straps(10'h389, 32'h0000_3000, 32'h0000_01e1, 32'h0000_0521, 1'b0);
    t_led;
    t_tx;
    t_rx;
    test_done;
  end
endmodule
